// ===== hw/pcs_count.sv
/*
  one statistics counter: wraps with a pulse in continuous mode,
  stops at all ones in single mode, clear keeps a same-cycle event.
  assumes the caller gates inc when the checker is halted.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_count #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         inc_in,
  input  wire logic         clr_in,
  input  wire logic         cont_in,
  output logic [W-1:0]      cnt_out,
  output logic              ovf_out,
  output logic              max_out
);

  localparam logic [W-1:0] ALL1 = '1;
  localparam logic [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};

  generate
    if (W < 2) begin : g_chk
      $error("pcs_count needs at least two bits");
    end
  endgenerate

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
    end else if (clr_in) begin
      cnt_q <= inc_in ? ONE : '0;
    end else if (inc_in && (cont_in || cnt_q != ALL1)) begin
      cnt_q <= cnt_q + ONE; // R11
    end
  end

  // single mode flags the arrival at all ones, continuous the wrap
  assign ovf_out = inc_in && !clr_in &&
                   (cont_in ? (cnt_q == ALL1) : (cnt_q == ALL1 - ONE));
  assign max_out = (cnt_q == ALL1);
  assign cnt_out = cnt_q;

  a_count_wrap: assert property (@(posedge clk_in) disable iff (!rstn_in)
    inc_in && cont_in && !clr_in && cnt_q == ALL1 |=> cnt_q == '0) // R11
    else $error("continuous counter did not restart from zero");

endmodule

`default_nettype wire

// ===== hw/pcs_gen.sv
/*
  frame generator tracking: send trigger, busy and done flags.
  assumes one sent pulse per checksummed frame leaving the generator.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_gen #(
  parameter int REQ_W = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             start_in,
  input  wire logic             stop_in,
  input  wire logic             enable_in,
  input  wire logic [REQ_W-1:0] req_in,
  input  wire logic             sent_in,
  output logic                  busy_out,
  output logic                  done_out,
  output logic                  send_out
);

  generate
    if (REQ_W < 1) begin : g_chk
      $error("pcs_gen needs a frame request width");
    end
  endgenerate

  pcs_pkg::pcs_gen_state_t state_q;
  logic [REQ_W-1:0]        sent_q;
  logic                    done_q;
  logic                    send_q;
  logic                    launch;
  logic                    empty_req;
  logic                    abort;
  logic                    finish;

  assign launch    = (state_q == pcs_pkg::PCS_IDLE) && start_in && enable_in;
  assign empty_req = (req_in == '0);
  assign abort     = (state_q == pcs_pkg::PCS_RUN) && (!enable_in || stop_in);
  assign finish    = (state_q == pcs_pkg::PCS_RUN) && !abort && sent_in &&
                     (sent_q + 1'b1 == req_in);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= pcs_pkg::PCS_IDLE;
    end else begin
      case (state_q)
        pcs_pkg::PCS_IDLE: begin
          if (launch && !empty_req) begin
            state_q <= pcs_pkg::PCS_RUN;
          end
        end
        pcs_pkg::PCS_RUN: begin
          if (abort || finish) begin
            state_q <= pcs_pkg::PCS_IDLE;
          end
        end
        default: begin
          state_q <= pcs_pkg::PCS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sent_q <= '0;
    end else if (launch) begin
      sent_q <= '0;
    end else if (state_q == pcs_pkg::PCS_RUN && sent_in) begin
      sent_q <= sent_q + 1'b1;
    end
  end

  // done drops when a new run starts and rises on completion or on a start with a zero request
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_q <= 1'b0;
    end else if (finish || (launch && empty_req)) begin
      done_q <= 1'b1; // R7
    end else if (launch) begin
      done_q <= 1'b0; // R7
    end
  end

  // trigger falls back by itself once the run completes or is aborted
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      send_q <= 1'b0;
    end else if (launch) begin
      send_q <= !empty_req;
    end else if (finish || abort) begin
      send_q <= 1'b0; // R12
    end
  end

  assign busy_out = (state_q == pcs_pkg::PCS_RUN); // R8
  assign done_out = done_q;
  assign send_out = send_q;

  a_done_not_busy: assert property (@(posedge clk_in) disable iff (!rstn_in)
    done_q |-> state_q == pcs_pkg::PCS_IDLE) // R7
    else $error("done flag set while generator still running");

  a_send_autoclr: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(done_q) |-> !send_q) // R12
    else $error("send trigger still set after done");

  a_busy_after: assert property (@(posedge clk_in) disable iff (!rstn_in)
    launch && !empty_req |=> busy_out && send_q && !done_q) // R8
    else $error("generator not busy after launch");

  c_gen_done: cover property (@(posedge clk_in) disable iff (!rstn_in)
    finish ##1 done_q);

endmodule

`default_nettype wire

// ===== hw/pcs_pkg.sv
/*
  types shared by the pattern checker statistics block.
  assumes pcs_regs.svh is on the include path.
*/
`include "pcs_regs.svh"

package pcs_pkg;

  typedef struct packed {
    logic [`PCS_BYTE_W-1:0]  bytes;
    logic [`PCS_FRAME_W-1:0] frames;
    logic [`PCS_ERR_W-1:0]   errs;
  } pcs_cnt_t;

  typedef struct packed {
    logic gen_en;
    logic cnt_cont;
  } pcs_ctrl_t;

  typedef enum logic [1:0] {
    PCS_IDLE,
    PCS_RUN
  } pcs_gen_state_t;

endpackage

// ===== hw/pcs_regs.svh
/*
  register offsets, field positions, widths and reset values of the
  pattern checker statistics block.
  assumes a 16-bit register port addressed by the printed offsets.
*/
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

`define PCS_ADDR_W          16
`define PCS_DATA_W          16
`define PCS_BYTE_W          16
`define PCS_FRAME_W         32
`define PCS_ERR_W           8
`define PCS_REQ_W           16

`define PCS_OFF_CTRL        16'h0619
`define PCS_OFF_BYTES       16'h061C
`define PCS_OFF_FRAME_LO    16'h061D
`define PCS_OFF_FRAME_HI    16'h061E
`define PCS_OFF_STATUS      16'h0620
`define PCS_OFF_FRAME_REQ   16'h0621

`define PCS_CTRL_GEN_EN     0
`define PCS_CTRL_CNT_MODE   3
`define PCS_CTRL_SEND       12

`define PCS_STAT_SNAP       0
`define PCS_STAT_CLEAR      1
`define PCS_STAT_ERR_MSB    7
`define PCS_STAT_LOCK       8
`define PCS_STAT_BYTE_OV    9
`define PCS_STAT_FRAME_OV   10
`define PCS_STAT_BUSY       11
`define PCS_STAT_DONE       12
`define PCS_STAT_RSV_LSB    13
`define PCS_STAT_RSV_MSB    15

`define PCS_FRAME_REQ_RST   16'h0001

`endif

// ===== hw/pcs_stats.sv
/*
  pattern checker statistics: byte, frame and bit-error counters with
  snapshot and clear, overflow, lock, generator busy and done status.
  assumes a single clock; datapath strobes are synchronous one-cycle
  pulses and the register port master never issues both strobes.
*/
// Added by the designer: the strobed register port.
// How it works
// R1 - sixteen-bit byte counter, stops at all ones
// R2 - thirty-two-bit frame counter, two halves, stops
// R3 - status bit 0 write snapshots all counters
// R4 - status bit 1 write snapshots then clears
// R5 - sticky frame overflow, cleared only by clear
// R6 - sticky byte overflow, cleared only by clear
// R7 - done set after all frames, low meanwhile
// R8 - busy reads one while generator runs
// R9 - lock bit shows checker alignment
// R10 - eight-bit error counter, stops at maximum
// R11 - count mode picks wrap-with-pulse or stop
// R12 - send trigger clears itself on done
// R13 - everything zero after reset except the frame request (one), reserved bits zero
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"

module pcs_stats (
  input  wire logic                   CLOCK_IN,
  input  wire logic                   RSTN_IN,
  input  wire logic [`PCS_ADDR_W-1:0] ADDR_IN,
  input  wire logic [`PCS_DATA_W-1:0] WDATA_IN,
  input  wire logic                   WR_IN,
  input  wire logic                   RD_IN,
  output logic      [`PCS_DATA_W-1:0] RDATA_OUT,
  input  wire logic                   BYTE_RX_IN,
  input  wire logic                   FRAME_RX_IN,
  input  wire logic                   BIT_ERR_IN,
  input  wire logic                   LOCK_IN,
  input  wire logic                   FRAME_SENT_IN,
  output logic                        GEN_RUN_OUT,
  output logic                        GEN_DONE_OUT,
  output logic                        CNT_WRAP_OUT
);

  function automatic logic hit(input logic [`PCS_ADDR_W-1:0] a,
                               input logic [`PCS_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  pcs_pkg::pcs_ctrl_t          ctrl_q;
  logic [`PCS_REQ_W-1:0]       frame_req_q;
  pcs_pkg::pcs_cnt_t           live;
  pcs_pkg::pcs_cnt_t           snap_q;
  logic                        byte_ov_q;
  logic                        frame_ov_q;
  logic                        wrap_q;
  logic [`PCS_DATA_W-1:0]      rdata_q;
  logic [`PCS_DATA_W-1:0]      rdata_d;
  logic                        wr_ctrl;
  logic                        wr_stat;
  logic                        snap_req;
  logic                        clr_req;
  logic                        halt;
  logic                        byte_inc;
  logic                        frame_inc;
  logic                        err_inc;
  logic                        byte_ovf;
  logic                        frame_ovf;
  logic                        err_ovf;
  logic                        byte_max;
  logic                        frame_max;
  logic                        err_max;
  logic                        gen_busy;
  logic                        gen_done;
  logic                        gen_send;

  assign wr_ctrl  = WR_IN && hit(ADDR_IN, `PCS_OFF_CTRL);
  assign wr_stat  = WR_IN && hit(ADDR_IN, `PCS_OFF_STATUS);
  assign snap_req = wr_stat && (WDATA_IN[`PCS_STAT_SNAP] ||
                                WDATA_IN[`PCS_STAT_CLEAR]); // R3
  assign clr_req  = wr_stat && WDATA_IN[`PCS_STAT_CLEAR]; // R4

  // single mode freezes all three counters once any counter tops out
  assign halt      = !ctrl_q.cnt_cont &&
                     (byte_max || frame_max || err_max); // R11
  assign byte_inc  = BYTE_RX_IN && !halt;
  assign frame_inc = FRAME_RX_IN && !halt;
  assign err_inc   = BIT_ERR_IN && !halt;

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q.gen_en   <= WDATA_IN[`PCS_CTRL_GEN_EN];
      ctrl_q.cnt_cont <= WDATA_IN[`PCS_CTRL_CNT_MODE]; // R11
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      frame_req_q <= `PCS_FRAME_REQ_RST;
    end else if (WR_IN && hit(ADDR_IN, `PCS_OFF_FRAME_REQ)) begin
      frame_req_q <= WDATA_IN[`PCS_REQ_W-1:0];
    end
  end

  pcs_count #(.W(`PCS_BYTE_W)) u_bytes (
    .clk_in  (CLOCK_IN),
    .rstn_in (RSTN_IN),
    .inc_in  (byte_inc),
    .clr_in  (clr_req),
    .cont_in (ctrl_q.cnt_cont),
    .cnt_out (live.bytes),
    .ovf_out (byte_ovf),
    .max_out (byte_max)
  ); // R1

  pcs_count #(.W(`PCS_FRAME_W)) u_frames (
    .clk_in  (CLOCK_IN),
    .rstn_in (RSTN_IN),
    .inc_in  (frame_inc),
    .clr_in  (clr_req),
    .cont_in (ctrl_q.cnt_cont),
    .cnt_out (live.frames),
    .ovf_out (frame_ovf),
    .max_out (frame_max)
  ); // R2

  pcs_count #(.W(`PCS_ERR_W)) u_errs (
    .clk_in  (CLOCK_IN),
    .rstn_in (RSTN_IN),
    .inc_in  (err_inc),
    .clr_in  (clr_req),
    .cont_in (ctrl_q.cnt_cont),
    .cnt_out (live.errs),
    .ovf_out (err_ovf),
    .max_out (err_max)
  ); // R10

  // the snapshot takes the values before a clear in the same cycle
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      snap_q <= '0;
    end else if (snap_req) begin
      snap_q <= live; // R3 R4
    end
  end

  // an overflow in the clear cycle is lost, since the counter masks its overflow pulse during a clear
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      byte_ov_q <= 1'b0;
    end else if (byte_ovf) begin
      byte_ov_q <= 1'b1; // R6
    end else if (clr_req) begin
      byte_ov_q <= 1'b0; // R6
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      frame_ov_q <= 1'b0;
    end else if (frame_ovf) begin
      frame_ov_q <= 1'b1; // R5
    end else if (clr_req) begin
      frame_ov_q <= 1'b0; // R5
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= ctrl_q.cnt_cont && (byte_ovf || frame_ovf || err_ovf); // R11
    end
  end

  pcs_gen #(.REQ_W(`PCS_REQ_W)) u_gen (
    .clk_in    (CLOCK_IN),
    .rstn_in   (RSTN_IN),
    .start_in  (wr_ctrl && WDATA_IN[`PCS_CTRL_SEND]),
    .stop_in   (wr_ctrl && !WDATA_IN[`PCS_CTRL_SEND]),
    .enable_in (ctrl_q.gen_en),
    .req_in    (frame_req_q),
    .sent_in   (FRAME_SENT_IN),
    .busy_out  (gen_busy),
    .done_out  (gen_done),
    .send_out  (gen_send)
  );

  always_comb begin
    rdata_d = '0;
    if (hit(ADDR_IN, `PCS_OFF_CTRL)) begin
      rdata_d[`PCS_CTRL_GEN_EN]   = ctrl_q.gen_en;
      rdata_d[`PCS_CTRL_CNT_MODE] = ctrl_q.cnt_cont;
      rdata_d[`PCS_CTRL_SEND]     = gen_send; // R12
    end else if (hit(ADDR_IN, `PCS_OFF_BYTES)) begin
      rdata_d = snap_q.bytes; // R1
    end else if (hit(ADDR_IN, `PCS_OFF_FRAME_LO)) begin
      rdata_d = snap_q.frames[`PCS_DATA_W-1:0]; // R2
    end else if (hit(ADDR_IN, `PCS_OFF_FRAME_HI)) begin
      rdata_d = snap_q.frames[`PCS_FRAME_W-1:`PCS_DATA_W]; // R2
    end else if (hit(ADDR_IN, `PCS_OFF_FRAME_REQ)) begin
      rdata_d = frame_req_q;
    end else if (hit(ADDR_IN, `PCS_OFF_STATUS)) begin
      rdata_d[`PCS_STAT_ERR_MSB:0]  = snap_q.errs; // R10
      rdata_d[`PCS_STAT_LOCK]       = LOCK_IN; // R9
      rdata_d[`PCS_STAT_BYTE_OV]    = byte_ov_q;
      rdata_d[`PCS_STAT_FRAME_OV]   = frame_ov_q;
      rdata_d[`PCS_STAT_BUSY]       = gen_busy; // R8
      rdata_d[`PCS_STAT_DONE]       = gen_done; // R7
    end
  end

  // read data stand for one cycle only; other cycles show zero
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdata_q <= '0; // R13
    end else begin
      rdata_q <= RD_IN ? rdata_d : '0;
    end
  end

  assign RDATA_OUT    = rdata_q;
  assign GEN_RUN_OUT  = gen_busy;
  assign GEN_DONE_OUT = gen_done;
  assign CNT_WRAP_OUT = wrap_q;

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  a_byte_saturate: assert property ( // R1
    !ctrl_q.cnt_cont && byte_max && !clr_req |=> byte_max)
    else $error("byte counter left all ones in single mode");

  a_frame_saturate: assert property ( // R2
    !ctrl_q.cnt_cont && frame_max && !clr_req |=> frame_max)
    else $error("frame counter left all ones in single mode");

  a_snap_capture: assert property ( // R3
    snap_req |=> snap_q == $past(live))
    else $error("snapshot does not hold the counter values");

  a_clear_zero: assert property ( // R4
    clr_req && !BYTE_RX_IN && !FRAME_RX_IN && !BIT_ERR_IN
    |=> live == '0)
    else $error("counters not cleared by clear write");

  a_frame_ov_sticky: assert property ( // R5
    frame_ov_q && !clr_req |=> frame_ov_q)
    else $error("frame overflow dropped without clear");

  a_byte_ov_set: assert property ( // R6
    byte_ovf |=> byte_ov_q)
    else $error("byte overflow not flagged");

  a_busy_readback: assert property ( // R8
    RD_IN && hit(ADDR_IN, `PCS_OFF_STATUS)
    |=> RDATA_OUT[`PCS_STAT_BUSY] == $past(gen_busy)
        && RDATA_OUT[`PCS_STAT_DONE] == $past(gen_done))
    else $error("busy or done bit misreported");

  a_lock_readback: assert property ( // R9
    RD_IN && hit(ADDR_IN, `PCS_OFF_STATUS)
    |=> RDATA_OUT[`PCS_STAT_LOCK] == $past(LOCK_IN))
    else $error("lock bit misreported");

  a_err_saturate: assert property ( // R10
    !ctrl_q.cnt_cont && err_max && !clr_req |=> err_max)
    else $error("error counter left maximum in single mode");

  a_wrap_pulse: assert property ( // R11
    ctrl_q.cnt_cont && byte_max && BYTE_RX_IN && !clr_req
    |=> live.bytes == '0 && CNT_WRAP_OUT && byte_ov_q)
    else $error("continuous wrap missing pulse or restart");

  a_rsv_zero: assert property ( // R13
    RDATA_OUT[`PCS_STAT_RSV_MSB:`PCS_STAT_RSV_LSB] == '0
    || !$past(hit(ADDR_IN, `PCS_OFF_STATUS)))
    else $error("reserved status bits not zero");

  c_clear_write: cover property (snap_req && clr_req);
  c_byte_wrap:   cover property (ctrl_q.cnt_cont && byte_ovf);
  c_single_stop: cover property (halt ##1 BYTE_RX_IN);
  c_status_read: cover property (RD_IN ##1 RDATA_OUT != '0);

endmodule

`default_nettype wire

// ===== testbench/pcs_stats_tb.sv
/*
  self-checking bench for the pattern checker statistics block.
  assumes pcs_regs.svh on the include path and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"

module pcs_stats_tb;
  logic                   clk      = 1'b0;
  logic                   rstn     = 1'b0;
  logic [`PCS_ADDR_W-1:0] addr     = 16'h0000;
  logic [`PCS_DATA_W-1:0] wdata    = 16'h0000;
  logic                   wr       = 1'b0;
  logic                   rd       = 1'b0;
  logic [`PCS_DATA_W-1:0] rdata;
  logic                   byte_rx  = 1'b0;
  logic                   frame_rx = 1'b0;
  logic                   bit_err  = 1'b0;
  logic                   lock     = 1'b0;
  logic                   sent     = 1'b0;
  logic                   gen_run;
  logic                   gen_done;
  logic                   cnt_wrap;
  int                     miscompares = 0;
  int                     cmp_count   = 0;
  int                     wraps       = 0;
  int                     w0;

  pcs_stats uut (
    .CLOCK_IN      (clk),
    .RSTN_IN       (rstn),
    .ADDR_IN       (addr),
    .WDATA_IN      (wdata),
    .WR_IN         (wr),
    .RD_IN         (rd),
    .RDATA_OUT     (rdata),
    .BYTE_RX_IN    (byte_rx),
    .FRAME_RX_IN   (frame_rx),
    .BIT_ERR_IN    (bit_err),
    .LOCK_IN       (lock),
    .FRAME_SENT_IN (sent),
    .GEN_RUN_OUT   (gen_run),
    .GEN_DONE_OUT  (gen_done),
    .CNT_WRAP_OUT  (cnt_wrap)
  );

  always #12.5 clk = ~clk;

  // the wrap output is a one-cycle pulse, so it is counted at every edge
  always @(posedge clk) begin
    if (cnt_wrap === 1'b1) begin
      wraps <= wraps + 1;
    end
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp,
                      input string msg);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp, msg);
  endtask

  // m is {sent, byte, frame, error}, held high for n back-to-back cycles
  task automatic stim(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      {sent, byte_rx, frame_rx, bit_err} <= m;
    end
    @(posedge clk);
    {sent, byte_rx, frame_rx, bit_err} <= 4'h0;
  endtask

  task automatic wait_done();
    int i;
    // look after the edge so the flag has settled
    #1;
    for (i = 0; i < 8 && gen_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (gen_done !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: done never came", $time);
      conclude();
    end
  endtask

  task automatic t_reset();
    #1;
    chk({13'h0000, gen_run, gen_done, cnt_wrap}, 16'h0000, "outs");
    rchk(`PCS_OFF_BYTES, 16'h0000, "bytes");
    rchk(`PCS_OFF_FRAME_LO, 16'h0000, "frame lo");
    rchk(`PCS_OFF_FRAME_HI, 16'h0000, "frame hi");
    rchk(`PCS_OFF_STATUS, 16'h0000, "status");
    rchk(`PCS_OFF_CTRL, 16'h0000, "ctrl");
    rchk(`PCS_OFF_FRAME_REQ, `PCS_FRAME_REQ_RST, "req");
    wreg(`PCS_OFF_FRAME_LO, 16'hFFFF);
    wreg(16'h0700, 16'hFFFF);
    rchk(`PCS_OFF_FRAME_LO, 16'h0000, "read-only kept");
    rchk(16'h0700, 16'h0000, "unmapped");
    @(posedge clk);
    #1;
    chk(rdata, 16'h0000, "rdata released");
    $display("test reset done");
  endtask

  task automatic t_snap();
    @(posedge clk);
    lock <= 1'b1;
    stim(4'h4, 5);
    stim(4'h2, 3);
    stim(4'h1, 2);
    wreg(`PCS_OFF_STATUS, 16'h0001);
    // later events must not disturb the held copy
    stim(4'h7, 4);
    rchk(`PCS_OFF_BYTES, 16'h0005, "snap bytes");
    rchk(`PCS_OFF_FRAME_LO, 16'h0003, "snap frames");
    rchk(`PCS_OFF_FRAME_HI, 16'h0000, "snap frames hi");
    rchk(`PCS_OFF_STATUS, 16'h0102, "lock and errs");
    wreg(`PCS_OFF_STATUS, 16'h0002);
    rchk(`PCS_OFF_BYTES, 16'h0009, "pre-clear bytes");
    rchk(`PCS_OFF_FRAME_LO, 16'h0007, "pre-clear frames");
    rchk(`PCS_OFF_STATUS, 16'h0106, "pre-clear errs");
    wreg(`PCS_OFF_STATUS, 16'h0001);
    lock <= 1'b0;
    rchk(`PCS_OFF_BYTES, 16'h0000, "cleared bytes");
    rchk(`PCS_OFF_STATUS, 16'h0000, "cleared, unlocked");
    $display("test snapshot done");
  endtask

  task automatic t_single();
    stim(4'h1, 300);
    // a saturated error count freezes the other counters too
    stim(4'h6, 4);
    wreg(`PCS_OFF_STATUS, 16'h0001);
    rchk(`PCS_OFF_STATUS, 16'h00FF, "err stops");
    rchk(`PCS_OFF_BYTES, 16'h0000, "bytes frozen");
    rchk(`PCS_OFF_FRAME_LO, 16'h0000, "frames frozen");
    wreg(`PCS_OFF_STATUS, 16'h0002);
    $display("test single mode done");
  endtask

  task automatic t_cont();
    wreg(`PCS_OFF_CTRL, 16'h0008);
    w0 = wraps;
    stim(4'h6, 65537);
    wreg(`PCS_OFF_STATUS, 16'h0001);
    rchk(`PCS_OFF_BYTES, 16'h0001, "byte wrapped");
    rchk(`PCS_OFF_FRAME_LO, 16'h0001, "frames lo");
    rchk(`PCS_OFF_FRAME_HI, 16'h0001, "frames hi");
    rchk(`PCS_OFF_STATUS, 16'h0200, "byte overflow");
    chk(16'(wraps - w0), 16'h0001, "one wrap pulse");
    stim(4'h1, 257);
    wreg(`PCS_OFF_STATUS, 16'h0001);
    rchk(`PCS_OFF_STATUS, 16'h0201, "err wrapped, flag sticky");
    chk(16'(wraps - w0), 16'h0002, "err wrap pulse");
    wreg(`PCS_OFF_STATUS, 16'h0002);
    wreg(`PCS_OFF_STATUS, 16'h0001);
    rchk(`PCS_OFF_STATUS, 16'h0000, "flag cleared");
    wreg(`PCS_OFF_CTRL, 16'h0000);
    $display("test continuous mode done");
  endtask

  task automatic t_gen();
    wreg(`PCS_OFF_CTRL, 16'h0001);
    wreg(`PCS_OFF_FRAME_REQ, 16'h0002);
    wreg(`PCS_OFF_CTRL, 16'h1001);
    #1;
    chk({14'h0000, gen_run, gen_done}, 16'h0002, "started");
    rchk(`PCS_OFF_CTRL, 16'h1001, "trigger reads 1");
    rchk(`PCS_OFF_STATUS, 16'h0800, "busy bit");
    stim(4'h8, 1);
    #1;
    chk({14'h0000, gen_run, gen_done}, 16'h0002, "one of two");
    stim(4'h8, 1);
    wait_done();
    chk({14'h0000, gen_run, gen_done}, 16'h0001, "all sent");
    rchk(`PCS_OFF_CTRL, 16'h0001, "trigger self-clears");
    rchk(`PCS_OFF_STATUS, 16'h1000, "done bit");
    wreg(`PCS_OFF_CTRL, 16'h1001);
    #1;
    chk({14'h0000, gen_run, gen_done}, 16'h0002, "restart");
    wreg(`PCS_OFF_CTRL, 16'h0001);
    #1;
    chk({14'h0000, gen_run, gen_done}, 16'h0000, "aborted");
    wreg(`PCS_OFF_FRAME_REQ, 16'h0000);
    wreg(`PCS_OFF_CTRL, 16'h1001);
    wait_done();
    chk({15'h0000, gen_run}, 16'h0000, "zero request idle");
    $display("test generator done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_snap();
    t_single();
    t_cont();
    t_gen();
    conclude();
  end
endmodule

`default_nettype wire
